// >>> core/link_reliability_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "link_reliability_defs.svh"

module link_reliability_monitor
  import link_reliability_pkg::*;
#(
  parameter int ERR_W         = 8,
  parameter int WIN_W         = 24,
  parameter int CYCLES_PER_US = `LRM_CYCLES_PER_US
) (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  input  wire logic [`LRM_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  input  wire logic                    crc_error,
  input  wire logic                    l0_to_recovery,
  input  wire logic [3:0]              recovery_cause,
  input  wire logic                    recovery_by_partner,
  input  wire logic                    link_retrain_request,
  input  wire logic                    link_down_detect,
  output logic                         unreliable_link_flag,
  output logic                         irq
);

  if (ERR_W != `LRM_THR_ERR_MSB - `LRM_THR_ERR_LSB + 1) begin : g_bad_err_w
    $error("ERR_W must match the threshold field width");
  end
  if (WIN_W != `LRM_THR_WIN_MSB - `LRM_THR_WIN_LSB + 1) begin : g_bad_win_w
    $error("WIN_W must match the window field width");
  end
  if (CYCLES_PER_US < 1) begin : g_bad_cycles
    $error("CYCLES_PER_US must be at least one");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`LRM_ADDR_W-1:0] a,
                               input logic [`LRM_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  control_t          control_q;
  logic              enable_prev_q;
  logic [ERR_W-1:0]  error_threshold_q;
  logic [WIN_W-1:0]  window_len_q;
  logic [ERR_W-1:0]  error_tally_q;
  logic [WIN_W-1:0]  window_tally_q;
  logic              flag_q;
  logic              irq_mask_q;
  logic              irq_q;
  logic [31:0]       rdata_q;

  usec_tick_if tick_bus ();

  usec_tick_gen #(
    .CYCLES_PER_US (CYCLES_PER_US)
  ) u_tick (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .tb      (tick_bus.source)
  );

  logic wr_control;
  logic wr_status;
  logic wr_threshold;
  logic wr_mask;
  assign wr_control   = reg_wr && hit(reg_addr, `LRM_OFF_CONTROL);
  assign wr_status    = reg_wr && hit(reg_addr, `LRM_OFF_STATUS);
  assign wr_threshold = reg_wr && hit(reg_addr, `LRM_OFF_THRESHOLD);
  assign wr_mask      = reg_wr && hit(reg_addr, `LRM_OFF_IRQ_MASK);

  // ----------------------------------------------------------------
  // Error event selection
  // ----------------------------------------------------------------
  logic link_state_err;
  logic error_event;
  logic clear_tallies;
  logic window_end;
  logic over_threshold;

  // Only self-initiated moves with a listed cause count
  assign link_state_err = l0_to_recovery && (|recovery_cause)
                          && !recovery_by_partner;

  always_comb begin
    case (control_q.err_type)
      ERR_TYPE_BIT:        error_event = crc_error;
      ERR_TYPE_LINK_STATE: error_event = link_state_err;
      default:             error_event = 1'b0;
    endcase
  end

  assign clear_tallies = link_retrain_request || link_down_detect
                         || (control_q.enable && !enable_prev_q);
  assign window_end     = (window_tally_q == window_len_q);
  assign over_threshold = (error_tally_q >= error_threshold_q);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      control_q     <= control_t'(`LRM_RST_CONTROL);
      enable_prev_q <= 1'b0;
    end else if (clk_en) begin
      enable_prev_q <= control_q.enable;
      if (wr_control) begin
        control_q.enable   <= reg_wdata[`LRM_CTL_EN_BIT];
        control_q.err_type <= err_type_t'(reg_wdata[`LRM_CTL_TYPE_BIT]);
      end
    end
  end

  // Zero is reserved for both fields; software is expected to avoid it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      error_threshold_q <= `LRM_RST_ERR_THR;
      window_len_q      <= `LRM_RST_WIN_LEN;
    end else if (clk_en && wr_threshold) begin
      error_threshold_q <= reg_wdata[`LRM_THR_ERR_MSB:`LRM_THR_ERR_LSB];
      window_len_q      <= reg_wdata[`LRM_THR_WIN_MSB:`LRM_THR_WIN_LSB];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_q <= `LRM_RST_IRQ_MASK;
    end else if (clk_en && wr_mask) begin
      irq_mask_q <= reg_wdata[`LRM_STS_FLAG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Error tally
  // ----------------------------------------------------------------
  // Runs regardless of the enable bit
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      error_tally_q <= '0;
    end else if (clk_en) begin
      if (clear_tallies) begin
        error_tally_q <= '0;
      end else if (flag_q) begin
        error_tally_q <= error_tally_q;
      end else if (window_end) begin
        error_tally_q <= '0;
      end else if (error_event && !(&error_tally_q)) begin
        error_tally_q <= error_tally_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Window tally, microsecond units
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      window_tally_q <= '0;
    end else if (clk_en) begin
      if (clear_tallies) begin
        window_tally_q <= '0;
      end else if (flag_q) begin
        window_tally_q <= window_tally_q;
      end else if (window_end) begin
        window_tally_q <= '0;
      end else if (tick_bus.tick && !(&window_tally_q)) begin
        window_tally_q <= window_tally_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Unreliable-link flag and interrupt
  // ----------------------------------------------------------------
  // Set wins over a same-cycle write-one clear
  // An enable rise waits one cycle, so a stale tally cannot set the flag
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (control_q.enable && enable_prev_q && over_threshold) begin
        flag_q <= 1'b1;
      end else if (wr_status && reg_wdata[`LRM_STS_FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= flag_q && irq_mask_q;
    end
  end

  // ----------------------------------------------------------------
  // Read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `LRM_OFF_CONTROL:   rdata_q <= {30'h0, control_q.err_type, control_q.enable};
          `LRM_OFF_STATUS:    rdata_q <= {31'h0, flag_q};
          `LRM_OFF_THRESHOLD: rdata_q <= {window_len_q, error_threshold_q};
          `LRM_OFF_COUNTERS:  rdata_q <= {window_tally_q, error_tally_q};
          `LRM_OFF_IRQ_MASK:  rdata_q <= {31'h0, irq_mask_q};
          default:            rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata            = rdata_q;
  assign unreliable_link_flag = flag_q;
  assign irq                  = irq_q;

endmodule

`default_nettype wire

// >>> core/usec_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

module usec_tick_gen #(
  parameter int CYCLES_PER_US = 40
) (
  input  wire logic   clock,
  input  wire logic   sys_rst,
  input  wire logic   clk_en,
  usec_tick_if.source tb
);

  localparam int CW = (CYCLES_PER_US > 1) ? $clog2(CYCLES_PER_US) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES_PER_US - 1);

  if (CYCLES_PER_US < 1) begin : g_bad_cycles
    $error("CYCLES_PER_US must be at least one");
  end

  logic [CW-1:0] div_q;
  logic          tick_q;

  // ----------------------------------------------------------------
  // Divider: one pulse per microsecond of core clock
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (div_q == LAST) begin
        div_q  <= '0;
        tick_q <= 1'b1;
      end else begin
        div_q  <= div_q + 1'b1;
        tick_q <= 1'b0;
      end
    end
  end

  assign tb.tick = tick_q;

endmodule

`default_nettype wire

// >>> include/link_reliability_defs.svh
// Contract
// - Monitor flags only while enable bit set; tallies run regardless of enable
// - Type zero counts link CRC errors
// - Type one counts caused L0-to-Recovery moves
// - Partner-initiated Recovery entries are ignored
// - Flag sets when tally reaches threshold
// - Flag sets only while monitoring enabled
// - Flag cleared only by software writing one
// - Eight-bit threshold field, default 0xFF
// - 24-bit microsecond window field, default 0xFFFFFF
// - Saturating error tally, cleared on retrain/down/enable
// - Tally freezes when unreliable, restarts at window end
// - Saturating microsecond window tally, same clears
// - Both tallies run while monitor disabled
`ifndef LINK_RELIABILITY_DEFS_SVH
`define LINK_RELIABILITY_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define LRM_ADDR_W          16
`define LRM_OFF_CONTROL     16'h0560
`define LRM_OFF_STATUS      16'h0564
`define LRM_OFF_THRESHOLD   16'h5680
`define LRM_OFF_COUNTERS    16'h056C
`define LRM_OFF_IRQ_MASK    16'h0570

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LRM_CTL_EN_BIT      0
`define LRM_CTL_TYPE_BIT    1
`define LRM_STS_FLAG_BIT    0
`define LRM_THR_ERR_LSB     0
`define LRM_THR_ERR_MSB     7
`define LRM_THR_WIN_LSB     8
`define LRM_THR_WIN_MSB     31

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LRM_RST_CONTROL     2'h0
`define LRM_RST_ERR_THR     8'hFF
`define LRM_RST_WIN_LEN     24'hFFFFFF
`define LRM_RST_IRQ_MASK    1'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LRM_CLK_PERIOD_NS   25
`define LRM_TIME_BASE_NS    1000
`define LRM_CYCLES_PER_US   (`LRM_TIME_BASE_NS / `LRM_CLK_PERIOD_NS)

`endif

// >>> include/link_reliability_pkg.sv
package link_reliability_pkg;

  typedef enum logic {
    ERR_TYPE_BIT        = 1'b0,
    ERR_TYPE_LINK_STATE = 1'b1
  } err_type_t;

  typedef struct packed {
    err_type_t err_type;
    logic      enable;
  } control_t;

endpackage

// >>> include/usec_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface usec_tick_if;
  logic tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface

`default_nettype wire

// >>> testbench/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

module link_partner_model (
  input  wire logic       clock,
  output var  logic       crc_error,
  output var  logic       l0_to_recovery,
  output var  logic [3:0] recovery_cause,
  output var  logic       recovery_by_partner,
  output var  logic       link_retrain_request,
  output var  logic       link_down_detect
);
  initial begin
    {crc_error, l0_to_recovery, recovery_by_partner} = 3'h0;
    {link_retrain_request, link_down_detect} = 2'h0;
    recovery_cause = 4'h0;
  end
  task automatic crc(input int n, input int g);
    repeat (n) begin
      @(posedge clock);
      crc_error <= 1'b1;
      @(posedge clock);
      crc_error <= 1'b0;
      repeat (g) @(posedge clock);
    end
  endtask
  // Qualifiers flip once the pulse is gone
  task automatic recov(input logic [3:0] c, input logic p);
    @(posedge clock);
    l0_to_recovery      <= 1'b1;
    recovery_cause      <= c;
    recovery_by_partner <= p;
    @(posedge clock);
    l0_to_recovery      <= 1'b0;
    recovery_cause      <= ~c;
    recovery_by_partner <= ~p;
  endtask
  task automatic clear(input logic down);
    @(posedge clock);
    link_retrain_request <= !down;
    link_down_detect     <= down;
    @(posedge clock);
    {link_retrain_request, link_down_detect} <= 2'h0;
  endtask
endmodule

`default_nettype wire

// >>> testbench/link_reliability_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "link_reliability_defs.svh"

module link_reliability_monitor_properties (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        link_retrain_request,
  input wire logic        link_down_detect,
  input wire logic        unreliable_link_flag,
  input wire logic        irq
);
  logic w1c;
  logic clr;
  assign w1c = reg_wr && reg_addr == `LRM_OFF_STATUS && reg_wdata[0];
  assign clr = link_retrain_request || link_down_detect;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence rd_s(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence clr_quiet_s;
    clr && !unreliable_link_flag ##1 !unreliable_link_flag;
  endsequence
  flag_hold_a: assert property (unreliable_link_flag && !w1c |=> unreliable_link_flag)
    else $error("flag dropped without clear");
  irq_off_a: assert property (!unreliable_link_flag |=> !irq)
    else $error("irq without flag");
  irq_rise_a: assert property ($rose(irq) |-> $past(unreliable_link_flag))
    else $error("irq rose ahead of flag");
  status_read_a: assert property (rd_s(`LRM_OFF_STATUS) |=>
    reg_rdata == {31'h0, $past(unreliable_link_flag)}) else $error("status read wrong");
  ctl_resv_a: assert property (rd_s(`LRM_OFF_CONTROL) |=> reg_rdata[31:2] == 30'h0)
    else $error("control reserved bits set");
  clear_quiet_a: assert property (clr_quiet_s |=> !unreliable_link_flag)
    else $error("flag set after tally clear");
  clear_read_a: assert property (clr ##1 rd_s(`LRM_OFF_COUNTERS) |=> reg_rdata == 32'h0)
    else $error("tallies not cleared");
  thr_read_a: assert property (reg_wr && reg_addr == `LRM_OFF_THRESHOLD
    ##1 rd_s(`LRM_OFF_THRESHOLD) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("threshold readback wrong");
endmodule

`default_nettype wire

// >>> testbench/link_reliability_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "link_reliability_defs.svh"

module link_reliability_monitor_tb;
  localparam int CPU = 4;
  logic        clock, sys_rst, reg_wr, reg_rd, flag, irq;
  logic        crc_error, l0_to_recovery, recovery_by_partner, retrain, down;
  logic [3:0]  recovery_cause;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0]  f;
  int          fails = 0, n_checks = 0, seed = 32'h3B86, n;

  link_reliability_monitor #(.CYCLES_PER_US(CPU)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crc_error(crc_error),
    .l0_to_recovery(l0_to_recovery), .recovery_cause(recovery_cause),
    .recovery_by_partner(recovery_by_partner), .link_retrain_request(retrain),
    .link_down_detect(down), .unreliable_link_flag(flag), .irq(irq));
  link_partner_model u_link (.clock(clock), .crc_error(crc_error),
    .l0_to_recovery(l0_to_recovery), .recovery_cause(recovery_cause),
    .recovery_by_partner(recovery_by_partner), .link_retrain_request(retrain),
    .link_down_detect(down));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_tally(input int k, input int cap);
    return (k > cap) ? cap : k;
  endfunction
  function automatic int gap();
    return $unsigned($random(seed)) % 3;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  // Starts at an edge, so it may follow a write with no gap
  task automatic rd(input logic [15:0] a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    f = {irq, flag};
    @(posedge clock);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, reg_wr, reg_rd} = 3'b100;
    reg_addr  = 16'h0;
    reg_wdata = 32'h0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`LRM_OFF_CONTROL);   chk("control", d, 32'h0);
    rd(`LRM_OFF_STATUS);    chk("status", d, 32'h0);
    rd(`LRM_OFF_THRESHOLD); chk("threshold", d, 32'hFFFFFFFF);
    wr(`LRM_OFF_IRQ_MASK, 32'h1);
    wr(`LRM_OFF_THRESHOLD, 32'h3E803);
    rd(`LRM_OFF_THRESHOLD); chk("thr readback", d, 32'h3E803);
    wr(`LRM_OFF_CONTROL, 32'h1);
    u_link.crc(2, gap());
    rd(`LRM_OFF_COUNTERS);  chk("tally", d[7:0], exp_tally(2, 3));
    chk("flag early", f, 2'b00);
    u_link.crc(3, gap());
    rd(`LRM_OFF_COUNTERS);  chk("frozen", d[7:0], exp_tally(5, 3));
    chk("flag irq", f, 2'b11);
    wr(`LRM_OFF_STATUS, 32'h0);
    rd(`LRM_OFF_STATUS);    chk("w0 keeps", d, 32'h1);
    fork
      u_link.clear(1'b0);
      begin
        repeat (2) @(posedge clock);
        rd(`LRM_OFF_COUNTERS);
      end
    join
    chk("retrain clr", d, 32'h0);
    wr(`LRM_OFF_STATUS, 32'h1);
    rd(`LRM_OFF_STATUS);    chk("w1c", d, 32'h0);
    wr(`LRM_OFF_CONTROL, 32'h0);
    wr(`LRM_OFF_THRESHOLD, 32'h3E808);
    wr(`LRM_OFF_CONTROL, 32'h3);
    for (int i = 0; i < 4; i++) u_link.recov(4'h1 << i, 1'b0);
    u_link.recov(4'h0, 1'b0);
    u_link.recov(4'hF, 1'b1);
    u_link.crc(2, gap());
    rd(`LRM_OFF_COUNTERS);  chk("link state", d[7:0], exp_tally(4, 8));
    wr(`LRM_OFF_CONTROL, 32'h0);
    wr(`LRM_OFF_THRESHOLD, 32'h3E804);
    u_link.clear(1'b1);
    n = 5 + $unsigned($random(seed)) % 16;
    u_link.crc(n, gap());
    rd(`LRM_OFF_COUNTERS);  chk("disabled", d[7:0], exp_tally(n, 255));
    chk("no flag", f, 2'b00);
    wr(`LRM_OFF_CONTROL, 32'h1);
    @(posedge clock);
    rd(`LRM_OFF_COUNTERS);  chk("en rise", d[7:0], 32'h0);
    chk("en rise flag", f, 2'b00);
    wr(`LRM_OFF_THRESHOLD, 32'h3FF);
    u_link.crc(1, 0);
    repeat (10 * CPU) @(posedge clock);
    rd(`LRM_OFF_COUNTERS);  chk("win restart", d[7:0], 32'h0);
    chk("win bound", d[31:8] <= 24'h3, 1'b1);
    wr(`LRM_OFF_THRESHOLD, 32'hFFFFFFFF);
    wr(`LRM_OFF_CONTROL, 32'h0);
    u_link.clear(1'b0);
    u_link.crc(300, 0);
    rd(`LRM_OFF_COUNTERS);  chk("saturate", d[7:0], exp_tally(300, 255));
    end_sim();
  end
endmodule

bind link_reliability_monitor link_reliability_monitor_properties u_props (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .link_retrain_request(link_retrain_request), .link_down_detect(link_down_detect),
  .unreliable_link_flag(unreliable_link_flag), .irq(irq));

`default_nettype wire
